// file: flash_write_pkg.sv
// Constants and carriers for the settings-write command decoder.
// Assumes one 40 MHz system clock and a report port of 64 byte strobes.
package flash_write_pkg;

	// -----------------------------------------------------------------
	// Report layout
	// -----------------------------------------------------------------
	localparam int REPORT_BYTES = 64;
	localparam int IDX_CMD = 0;
	localparam int IDX_SUB = 1;
	localparam int IDX_CHIP_A = 2;
	localparam int IDX_CHIP_B = 3;
	localparam int IDX_CHIP_C = 4;
	localparam int PAYLOAD_FIRST = 2;
	localparam logic [7:0] CMD_WRITE_NV = 8'hB1;
	localparam logic [7:0] STATUS_OK = 8'h00;
	localparam logic [7:0] STATUS_UNSUPPORTED = 8'h01;
	localparam logic [5:0] LAST_INDEX = 6'h3F;

	typedef enum logic [7:0] {
		SUB_CHIP = 8'h00,
		SUB_PINS = 8'h01,
		SUB_MFR_STR = 8'h02,
		SUB_PROD_STR = 8'h03,
		SUB_SERIAL_STR = 8'h04
	} sub_cmd_t;

	// -----------------------------------------------------------------
	// Chip settings field positions
	// -----------------------------------------------------------------
	localparam int BIT_SERIAL_EN = 7;
	localparam int BIT_RX_IDLE = 6;
	localparam int BIT_TX_IDLE = 5;
	localparam int BIT_TW_IDLE = 4;
	localparam int BIT_SUSP_IDLE = 3;
	localparam int BIT_CFG_IDLE = 2;
	localparam int SEC_LSB = 0;
	localparam int CLKDIV_LSB = 0;
	localparam int DACREF_LSB = 6;
	localparam int DACSRC_BIT = 5;
	localparam int DACCODE_LSB = 0;

	typedef enum logic [1:0] {
		SEC_OPEN = 2'h0,
		SEC_PASSWORD = 2'h1,
		SEC_LOCKED = 2'h2
	} security_t;

	typedef enum logic [1:0] {
		VREF_OFF = 2'h0,
		VREF_LOW = 2'h1,
		VREF_MID = 2'h2,
		VREF_HIGH = 2'h3
	} vref_t;

	typedef struct packed {
		logic serial_enum_en;
		logic rx_idle;
		logic tx_idle;
		logic tw_idle;
		logic susp_idle;
		logic cfg_idle;
		security_t security;
		logic [4:0] clk_div;
		vref_t dac_vref;
		logic dac_use_supply;
		logic [4:0] dac_code;
	} chip_settings_t;

	typedef struct packed {
		logic rx_busy;
		logic tx_busy;
		logic tw_busy;
		logic tw_led_en;
		logic suspended;
		logic susp_led_en;
		logic configured;
		logic cfg_led_en;
	} activity_t;

	// Reset values of the committed settings
	localparam chip_settings_t CHIP_RESET = '0;

	// Interrupt status/mask bit positions
	localparam int EV_WRITE_DONE = 0;
	localparam int EV_UNSUPPORTED = 1;
	localparam int EV_COUNT = 2;

	// Clock-out: 48 MHz is not available; divider counts 48 MHz tick enables
	localparam int SYS_CLK_HZ = 40000000;
	localparam int USB_CLK_HZ = 48000000;

	// Register port map
	localparam logic [3:0] REG_IRQ_STATUS = 4'h0;
	localparam logic [3:0] REG_IRQ_MASK = 4'h1;
	localparam logic [3:0] REG_LAST_STATUS = 4'h2;
	localparam logic [3:0] REG_SETTINGS_LO = 4'h3;
	localparam logic [3:0] REG_SETTINGS_HI = 4'h4;
	localparam logic [3:0] REG_SUB_SEEN = 4'h5;

endpackage

// file: flash_write_command_decoder.sv
// Decoder for the nonvolatile settings-write report and the pins it steers.
// Assumes report bytes arrive one per valid strobe, gaps allowed, with a first-byte marker,
// and that the nonvolatile store takes a one-cycle commit pulse.
//
// What this block does
// - Byte 0 command code marks settings write
// - Byte 1 selects chip, pins, three strings
// - Unknown selector: no write, unsupported status
// - Bytes 2-63 are payload per selector
// - Byte 2 bit 7 enables serial enumeration
// - Rx indicator inverts idle level while receiving
// - Tx indicator inverts idle level while sending
// - Two-wire indicator inverts while traffic, enabled
// - Suspend indicator inverts in suspend, enabled
// - Configured indicator inverts once configured, enabled
// - Byte 2 bits 1-0 choose security option
// - Byte 3 bits 4-0 divide clock output
// - Byte 4 bits 7-6 choose DAC reference
// - Byte 4 bit 5 selects supply reference
// - Byte 4 bits 4-0 power-up DAC code
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module flash_write_command_decoder
	import flash_write_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic RPT_VALID,
	input wire logic RPT_FIRST,
	input wire logic [7:0] RPT_BYTE,
	input wire activity_t ACTIVITY,
	input wire logic CLKOUT_EN,
	input wire logic USB_CLK_TICK,
	input wire logic [3:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	output logic RESP_VALID,
	output logic [7:0] RESP_CMD,
	output logic [7:0] RESP_STATUS,
	output logic NV_COMMIT,
	output logic [7:0] NV_SUBCMD,
	output chip_settings_t NV_CHIP,
	output logic [5:0] NV_INDEX,
	output logic [7:0] NV_DATA,
	output logic NV_DATA_VALID,
	output logic RX_ACTIVITY_INDICATOR,
	output logic TX_ACTIVITY_INDICATOR,
	output logic TWOWIRE_ACTIVITY_INDICATOR,
	output logic SUSPEND_INDICATOR,
	output logic CONFIGURED_INDICATOR,
	output logic CLK_OUT,
	output logic SERIAL_ENUM_EN,
	output security_t SECURITY,
	output vref_t DAC_VREF,
	output logic DAC_USE_SUPPLY,
	output logic [4:0] DAC_CODE,
	output logic IRQ
);

	// ---------------------------------------------------------------
	// Report byte tracking
	// ---------------------------------------------------------------
	logic [5:0] idx_q;
	logic [5:0] cur_idx;
	logic active_q;
	logic is_write_q;
	logic [7:0] sub_q;
	logic sub_ok;
	chip_settings_t staged_q;
	chip_settings_t live_q;
	logic [EV_COUNT-1:0] irq_status_q;
	logic [EV_COUNT-1:0] irq_mask_q;
	logic [EV_COUNT-1:0] ev_set;
	logic [7:0] last_status_q;
	logic done_pulse;

	assign cur_idx = RPT_FIRST ? 6'h00 : idx_q;

	always_comb begin
		case (sub_q)
			SUB_CHIP, SUB_PINS, SUB_MFR_STR, SUB_PROD_STR, SUB_SERIAL_STR: sub_ok = 1'b1;
			default: sub_ok = 1'b0;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			idx_q <= 6'h00;
			active_q <= 1'b0;
		end else if (RPT_VALID) begin
			idx_q <= cur_idx + 6'h01;
			active_q <= (cur_idx != LAST_INDEX);
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			is_write_q <= 1'b0;
			sub_q <= 8'h00;
		end else if (RPT_VALID) begin
			if (cur_idx == 6'(IDX_CMD)) begin
				is_write_q <= (RPT_BYTE == CMD_WRITE_NV);
			end
			if (cur_idx == 6'(IDX_SUB)) begin
				sub_q <= RPT_BYTE;
			end
		end
	end

	// ---------------------------------------------------------------
	// Chip settings staging
	// ---------------------------------------------------------------
	// Staged separately so a report cut short never disturbs live settings
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			staged_q <= CHIP_RESET;
		end else if (RPT_VALID && is_write_q && sub_q == SUB_CHIP) begin
			if (cur_idx == 6'(IDX_CHIP_A)) begin
				staged_q.serial_enum_en <= RPT_BYTE[BIT_SERIAL_EN];
				staged_q.rx_idle <= RPT_BYTE[BIT_RX_IDLE];
				staged_q.tx_idle <= RPT_BYTE[BIT_TX_IDLE];
				staged_q.tw_idle <= RPT_BYTE[BIT_TW_IDLE];
				staged_q.susp_idle <= RPT_BYTE[BIT_SUSP_IDLE];
				staged_q.cfg_idle <= RPT_BYTE[BIT_CFG_IDLE];
				// Both upper codes mean locked
				if (RPT_BYTE[SEC_LSB+1]) begin
					staged_q.security <= SEC_LOCKED;
				end else begin
					staged_q.security <= security_t'({1'b0, RPT_BYTE[SEC_LSB]});
				end
			end
			if (cur_idx == 6'(IDX_CHIP_B)) begin
				staged_q.clk_div <= RPT_BYTE[CLKDIV_LSB +: 5];
			end
			if (cur_idx == 6'(IDX_CHIP_C)) begin
				staged_q.dac_vref <= vref_t'(RPT_BYTE[DACREF_LSB +: 2]);
				staged_q.dac_use_supply <= RPT_BYTE[DACSRC_BIT];
				staged_q.dac_code <= RPT_BYTE[DACCODE_LSB +: 5];
			end
		end
	end

	// ---------------------------------------------------------------
	// Commit and response
	// ---------------------------------------------------------------
	assign done_pulse = RPT_VALID && active_q && is_write_q && cur_idx == LAST_INDEX;

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			live_q <= CHIP_RESET;
			NV_COMMIT <= 1'b0;
			NV_SUBCMD <= 8'h00;
			NV_CHIP <= CHIP_RESET;
			RESP_VALID <= 1'b0;
			RESP_CMD <= 8'h00;
			RESP_STATUS <= STATUS_OK;
			last_status_q <= STATUS_OK;
		end else begin
			NV_COMMIT <= done_pulse && sub_ok;
			RESP_VALID <= done_pulse;
			if (done_pulse) begin
				RESP_CMD <= CMD_WRITE_NV;
				RESP_STATUS <= sub_ok ? STATUS_OK : STATUS_UNSUPPORTED;
				last_status_q <= sub_ok ? STATUS_OK : STATUS_UNSUPPORTED;
				NV_SUBCMD <= sub_q;
				if (sub_q == SUB_CHIP) begin
					live_q <= staged_q;
					NV_CHIP <= staged_q;
				end
			end
		end
	end

	// Pin, string payload bytes stream to the store as they arrive
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			NV_DATA_VALID <= 1'b0;
			NV_INDEX <= 6'h00;
			NV_DATA <= 8'h00;
		end else begin
			NV_DATA_VALID <= RPT_VALID && is_write_q && sub_ok && sub_q != SUB_CHIP
				&& cur_idx >= 6'(PAYLOAD_FIRST);
			NV_INDEX <= cur_idx;
			NV_DATA <= RPT_BYTE;
		end
	end

	// ---------------------------------------------------------------
	// Indicator pins and settings outputs
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			RX_ACTIVITY_INDICATOR <= 1'b0;
			TX_ACTIVITY_INDICATOR <= 1'b0;
			TWOWIRE_ACTIVITY_INDICATOR <= 1'b0;
			SUSPEND_INDICATOR <= 1'b0;
			CONFIGURED_INDICATOR <= 1'b0;
			SERIAL_ENUM_EN <= 1'b0;
			SECURITY <= SEC_OPEN;
			DAC_VREF <= VREF_OFF;
			DAC_USE_SUPPLY <= 1'b0;
			DAC_CODE <= 5'h00;
		end else begin
			RX_ACTIVITY_INDICATOR <= live_q.rx_idle ^ ACTIVITY.rx_busy;
			TX_ACTIVITY_INDICATOR <= live_q.tx_idle ^ ACTIVITY.tx_busy;
			TWOWIRE_ACTIVITY_INDICATOR <= live_q.tw_idle
				^ (ACTIVITY.tw_busy & ACTIVITY.tw_led_en);
			SUSPEND_INDICATOR <= live_q.susp_idle
				^ (ACTIVITY.suspended & ACTIVITY.susp_led_en);
			CONFIGURED_INDICATOR <= live_q.cfg_idle
				^ (ACTIVITY.configured & ACTIVITY.cfg_led_en);
			SERIAL_ENUM_EN <= live_q.serial_enum_en;
			SECURITY <= live_q.security;
			DAC_VREF <= live_q.dac_use_supply ? VREF_OFF : live_q.dac_vref;
			DAC_USE_SUPPLY <= live_q.dac_use_supply;
			DAC_CODE <= live_q.dac_code;
		end
	end

	// ---------------------------------------------------------------
	// Clock output divider
	// ---------------------------------------------------------------
	// The 48 MHz source arrives as a tick enable; each half period is
	// the divider value in ticks, zero treated as one.
	logic [4:0] div_cnt_q;

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			div_cnt_q <= 5'h00;
			CLK_OUT <= 1'b0;
		end else if (!CLKOUT_EN) begin
			div_cnt_q <= 5'h00;
			CLK_OUT <= 1'b0;
		end else if (USB_CLK_TICK) begin
			if (div_cnt_q + 5'h01 >= live_q.clk_div || live_q.clk_div == 5'h00) begin
				div_cnt_q <= 5'h00;
				CLK_OUT <= ~CLK_OUT;
			end else begin
				div_cnt_q <= div_cnt_q + 5'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// Interrupts and register port
	// ---------------------------------------------------------------
	assign ev_set[EV_WRITE_DONE] = done_pulse && sub_ok;
	assign ev_set[EV_UNSUPPORTED] = done_pulse && !sub_ok;

	// Set wins over a clear in the same cycle
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			irq_status_q <= '0;
		end else begin
			irq_status_q <= (irq_status_q
				& ~((REG_WR && REG_ADDR == REG_IRQ_STATUS) ? REG_WDATA[EV_COUNT-1:0] : '0))
				| ev_set;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			irq_mask_q <= '0;
		end else if (REG_WR && REG_ADDR == REG_IRQ_MASK) begin
			irq_mask_q <= REG_WDATA[EV_COUNT-1:0];
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(irq_status_q & irq_mask_q);
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			case (REG_ADDR)
				REG_IRQ_STATUS: REG_RDATA <= {6'h00, irq_status_q};
				REG_IRQ_MASK: REG_RDATA <= {6'h00, irq_mask_q};
				REG_LAST_STATUS: REG_RDATA <= last_status_q;
				REG_SETTINGS_LO: REG_RDATA <= {live_q.serial_enum_en, live_q.rx_idle,
					live_q.tx_idle, live_q.tw_idle, live_q.susp_idle, live_q.cfg_idle,
					live_q.security};
				REG_SETTINGS_HI: REG_RDATA <= {live_q.dac_vref, live_q.dac_use_supply,
					live_q.dac_code};
				REG_SUB_SEEN: REG_RDATA <= sub_q;
				default: REG_RDATA <= 8'h00;
			endcase
		end else begin
			REG_RDATA <= 8'h00;
		end
	end

endmodule // flash_write_command_decoder

// file: flash_host_model.sv
// Host model: streams one 64-byte command report per go pulse.
// Assumes the bench raises go for one cycle, then waits while busy is high.
`timescale 1ns/1ps
module flash_host_model (
	input wire logic CLK_SYS,
	input wire logic go,
	input wire logic slow,
	input wire logic [511:0] rpt,
	output logic busy,
	output logic RPT_VALID,
	output logic RPT_FIRST,
	output logic [7:0] RPT_BYTE
);
	initial begin
		busy = 1'b0;
		RPT_VALID = 1'b0;
		RPT_FIRST = 1'b0;
		RPT_BYTE = 8'h00;
		forever begin
			@(posedge CLK_SYS);
			if (go) begin
				busy <= 1'b1;
				for (int i = 0; i < 64; i++) begin
					RPT_VALID <= 1'b1;
					RPT_FIRST <= (i == 0);
					RPT_BYTE <= rpt[i*8 +: 8];
					@(posedge CLK_SYS);
					if (slow) begin
						// Released line shows the inverse so stale data cannot pass
						RPT_VALID <= 1'b0;
						RPT_FIRST <= 1'b0;
						RPT_BYTE <= ~rpt[i*8 +: 8];
						@(posedge CLK_SYS);
					end
				end
				RPT_VALID <= 1'b0;
				RPT_FIRST <= 1'b0;
				RPT_BYTE <= ~rpt[511:504];
				busy <= 1'b0;
			end
		end
	end
endmodule // flash_host_model

// file: flash_write_command_decoder_asserts.sv
// Checker for the report responses and the settings that a commit applies.
// Assumes binding to the decoder top module, one clock domain.
`timescale 1ns/1ps
module flash_write_command_decoder_asserts
	import flash_write_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire activity_t ACTIVITY,
	input wire logic RESP_VALID,
	input wire logic [7:0] RESP_CMD,
	input wire logic [7:0] RESP_STATUS,
	input wire logic NV_COMMIT,
	input wire logic [7:0] NV_SUBCMD,
	input wire chip_settings_t NV_CHIP,
	input wire logic RX_ACTIVITY_INDICATOR,
	input wire logic TWOWIRE_ACTIVITY_INDICATOR,
	input wire logic SERIAL_ENUM_EN,
	input wire security_t SECURITY,
	input wire vref_t DAC_VREF,
	input wire logic DAC_USE_SUPPLY,
	input wire logic [4:0] DAC_CODE
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	echo_code_a: assert property (RESP_VALID |-> RESP_CMD == CMD_WRITE_NV)
		else $error("response echo wrong");
	commit_sub_a: assert property (NV_COMMIT |-> NV_SUBCMD <= 8'h04)
		else $error("commit for unknown selector");
	bad_nocommit_a: assert property (
		RESP_VALID && RESP_STATUS == STATUS_UNSUPPORTED |-> !NV_COMMIT)
		else $error("unsupported selector committed");
	commit_ok_a: assert property (NV_COMMIT |-> RESP_VALID && RESP_STATUS == STATUS_OK)
		else $error("commit without ok response");
	serial_apply_a: assert property (
		NV_COMMIT && NV_SUBCMD == 8'h00 |=> SERIAL_ENUM_EN == $past(NV_CHIP.serial_enum_en))
		else $error("serial enable not applied");
	dac_apply_a: assert property (
		NV_COMMIT && NV_SUBCMD == 8'h00 |=> DAC_CODE == $past(NV_CHIP.dac_code)
		&& DAC_USE_SUPPLY == $past(NV_CHIP.dac_use_supply))
		else $error("dac setting not applied");
	vref_apply_a: assert property (
		NV_COMMIT && NV_SUBCMD == 8'h00 |=> DAC_VREF ==
		($past(NV_CHIP.dac_use_supply) ? VREF_OFF : $past(NV_CHIP.dac_vref)))
		else $error("reference level wrong");
	sec_apply_a: assert property (
		NV_COMMIT && NV_SUBCMD == 8'h00 |=> SECURITY == $past(NV_CHIP.security))
		else $error("security option wrong");
	rx_level_a: assert property (
		NV_COMMIT && NV_SUBCMD == 8'h00 ##1 !NV_COMMIT |=>
		RX_ACTIVITY_INDICATOR == (NV_CHIP.rx_idle ^ $past(ACTIVITY.rx_busy)))
		else $error("rx indicator level wrong");
	tw_level_a: assert property (
		NV_COMMIT && NV_SUBCMD == 8'h00 ##1 !NV_COMMIT |=> TWOWIRE_ACTIVITY_INDICATOR
		== (NV_CHIP.tw_idle ^ ($past(ACTIVITY.tw_busy) & $past(ACTIVITY.tw_led_en))))
		else $error("two-wire indicator level wrong");
endmodule // flash_write_command_decoder_asserts
bind flash_write_command_decoder flash_write_command_decoder_asserts
	i_flash_write_command_decoder_asserts (
	.CLK_SYS, .RST_B, .ACTIVITY, .RESP_VALID, .RESP_CMD, .RESP_STATUS, .NV_COMMIT, .NV_SUBCMD,
	.NV_CHIP, .RX_ACTIVITY_INDICATOR, .TWOWIRE_ACTIVITY_INDICATOR, .SERIAL_ENUM_EN, .SECURITY,
	.DAC_VREF, .DAC_USE_SUPPLY, .DAC_CODE);

// file: flash_write_command_decoder_tb.sv
// Bench: command reports through the host model, register port, indicators.
// Assumes flash_host_model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module flash_write_command_decoder_tb;
	import flash_write_pkg::*;
	logic CLK_SYS = 1'b0;
	logic RST_B = 1'b0;
	activity_t ACTIVITY = '0;
	logic CLKOUT_EN = 1'b0;
	logic USB_CLK_TICK = 1'b0;
	logic [3:0] REG_ADDR = 4'h0;
	logic [7:0] REG_WDATA = 8'h00;
	logic REG_WR = 1'b0;
	logic REG_RD = 1'b0;
	logic go = 1'b0;
	logic slow = 1'b0;
	logic busy;
	logic [511:0] rpt = '0;
	logic RPT_VALID, RPT_FIRST, RESP_VALID, NV_COMMIT, NV_DATA_VALID, IRQ, CLK_OUT;
	logic SERIAL_ENUM_EN, DAC_USE_SUPPLY, RX_ACTIVITY_INDICATOR, TX_ACTIVITY_INDICATOR;
	logic TWOWIRE_ACTIVITY_INDICATOR, SUSPEND_INDICATOR, CONFIGURED_INDICATOR;
	logic [7:0] RPT_BYTE, REG_RDATA, RESP_CMD, RESP_STATUS, NV_DATA;
	logic [5:0] NV_INDEX;
	logic [4:0] DAC_CODE;
	security_t SECURITY;
	vref_t DAC_VREF;
	int error_cnt = 0;
	int checks = 0;
	int resp_n = 0, com_n = 0, dv_n = 0, cyc = 0, n, m;
	logic [7:0] b2[3] = '{8'hB6, 8'h41, 8'h03};
	logic [7:0] b3[3] = '{8'hE3, 8'h02, 8'hA1};
	logic [7:0] b4[3] = '{8'hA7, 8'hDF, 8'h41};
	logic [7:0] e3[3] = '{8'hB6, 8'h41, 8'h02};
	logic [7:0] acts[3] = '{8'hFF, 8'hAA, 8'h00};
	logic [4:0] msk[3] = '{5'h1F, 5'h10, 5'h00};
	logic [15:0] eo[3] = '{16'h0627, 16'h01DF, 16'h0241};
	logic [7:0] subs[6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'hFF};

	flash_host_model i_flash_host_model (.CLK_SYS, .go, .slow, .rpt, .busy, .RPT_VALID,
		.RPT_FIRST, .RPT_BYTE);
	flash_write_command_decoder i_flash_write_command_decoder (.CLK_SYS, .RST_B, .RPT_VALID,
		.RPT_FIRST, .RPT_BYTE, .ACTIVITY, .CLKOUT_EN, .USB_CLK_TICK, .REG_ADDR, .REG_WDATA,
		.REG_WR, .REG_RD, .REG_RDATA, .RESP_VALID, .RESP_CMD, .RESP_STATUS, .NV_COMMIT,
		.NV_SUBCMD(), .NV_CHIP(), .NV_INDEX, .NV_DATA, .NV_DATA_VALID, .RX_ACTIVITY_INDICATOR,
		.TX_ACTIVITY_INDICATOR, .TWOWIRE_ACTIVITY_INDICATOR, .SUSPEND_INDICATOR,
		.CONFIGURED_INDICATOR, .CLK_OUT, .SERIAL_ENUM_EN, .SECURITY, .DAC_VREF, .DAC_USE_SUPPLY,
		.DAC_CODE, .IRQ);

	initial forever #12.5 CLK_SYS = ~CLK_SYS;

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Whole run is about 900 cycles; the ceiling leaves ample slack
	always @(posedge CLK_SYS) begin
		cyc++;
		if (RESP_VALID === 1'b1) resp_n++;
		if (NV_COMMIT === 1'b1) com_n++;
		if (NV_DATA_VALID === 1'b1) begin
			dv_n++;
			chk({8'h00, NV_DATA}, {8'h00, rpt[NV_INDEX*8 +: 8]});
		end
		if (cyc == 8000) begin
			error_cnt++;
			$display("unexpected at %0t: timeout", $time);
			print_verdict;
		end
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge CLK_SYS);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLK_SYS);
		REG_WR <= 1'b0;
	endtask

	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		@(posedge CLK_SYS);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLK_SYS);
		REG_RD <= 1'b0;
		@(posedge CLK_SYS);
		chk({8'h00, REG_RDATA}, {8'h00, e});
	endtask

	task automatic send(input logic [7:0] c, s, x2, x3, x4, input logic sl);
		for (int i = 0; i < 64; i++) rpt[i*8 +: 8] = 8'(i);
		rpt[39:0] = {x4, x3, x2, s, c};
		slow = sl;
		@(posedge CLK_SYS);
		go <= 1'b1;
		@(posedge CLK_SYS);
		go <= 1'b0;
		@(posedge CLK_SYS);
		for (int i = 0; i < 300 && busy; i++) @(posedge CLK_SYS);
		repeat (4) @(posedge CLK_SYS);
	endtask

	// Interval between two output toggles, in system cycles
	task automatic gap(output int g);
		logic v;
		g = 0;
		@(posedge CLK_SYS);
		v = CLK_OUT;
		for (int i = 0; i < 40 && CLK_OUT === v; i++) @(posedge CLK_SYS);
		v = CLK_OUT;
		while (CLK_OUT === v && g < 40) begin
			@(posedge CLK_SYS);
			g++;
		end
	endtask

	initial begin
		repeat (20) @(posedge CLK_SYS);
		RST_B <= 1'b1;
		USB_CLK_TICK <= 1'b1;
		CLKOUT_EN <= 1'b1;
		chk({5'h0, SERIAL_ENUM_EN, SECURITY, DAC_VREF, DAC_USE_SUPPLY, DAC_CODE},
			16'h0000);
		reg_wr(REG_IRQ_MASK, 8'h03);
		send(8'hB0, 8'h00, 8'hFF, 8'h1F, 8'hFF, 1'b0);
		chk(16'(resp_n), 16'h0000);
		rchk(REG_SETTINGS_LO, 8'h00);
		$display("test foreign code done");
		for (int k = 0; k < 3; k++) begin
			ACTIVITY <= activity_t'(acts[k]);
			send(CMD_WRITE_NV, 8'h00, b2[k], b3[k], b4[k], k[0]);
			chk({5'h0, SERIAL_ENUM_EN, SECURITY, DAC_VREF, DAC_USE_SUPPLY, DAC_CODE},
				eo[k]);
			chk({11'h0, RX_ACTIVITY_INDICATOR, TX_ACTIVITY_INDICATOR, TWOWIRE_ACTIVITY_INDICATOR,
				SUSPEND_INDICATOR, CONFIGURED_INDICATOR},
				{11'h0, b2[k][6:2] ^ msk[k]});
			rchk(REG_SETTINGS_LO, e3[k]);
			rchk(REG_SETTINGS_HI, b4[k]);
			gap(n);
			chk(16'(n), {11'h0, b3[k][4:0]});
		end
		// Divider is 1 here, so a missing hold would show as a toggle
		CLKOUT_EN <= 1'b0;
		repeat (2) @(posedge CLK_SYS);
		chk({15'h0, CLK_OUT}, 16'h0000);
		@(posedge CLK_SYS);
		chk({15'h0, CLK_OUT}, 16'h0000);
		CLKOUT_EN <= 1'b1;
		$display("test chip settings done");
		for (int k = 0; k < 6; k++) begin
			n = com_n;
			m = dv_n;
			send(CMD_WRITE_NV, subs[k], 8'h12, 8'h34, 8'h56, 1'b0);
			chk({RESP_CMD, RESP_STATUS},
				{CMD_WRITE_NV, k > 3 ? STATUS_UNSUPPORTED : STATUS_OK});
			chk(16'(com_n - n), k > 3 ? 16'h0000 : 16'h0001);
			chk(16'(dv_n - m), k > 3 ? 16'h0000 : 16'h003E);
			rchk(REG_LAST_STATUS, k > 3 ? STATUS_UNSUPPORTED : STATUS_OK);
			rchk(REG_SUB_SEEN, subs[k]);
		end
		rchk(REG_SETTINGS_LO, e3[2]);
		$display("test selectors done");
		rchk(REG_IRQ_STATUS, 8'h03);
		chk({15'h0, IRQ}, 16'h0001);
		reg_wr(REG_IRQ_MASK, 8'h00);
		repeat (2) @(posedge CLK_SYS);
		chk({15'h0, IRQ}, 16'h0000);
		reg_wr(REG_IRQ_STATUS, 8'h03);
		rchk(REG_IRQ_STATUS, 8'h00);
		rchk(4'hF, 8'h00);
		$display("test interrupts done");
		print_verdict;
	end
endmodule // flash_write_command_decoder_tb
